// ==== psl_pkg.sv ====
// shared constants and types for the passive serial configuration link
//
// Notes on behaviour
// RL1 - user mode: request, ready, complete all high
// RL2 - request low restarts configuration, leaves user mode
// RL3 - ready held low through power-on delay
// RL4 - complete low until whole bitstream accepted
// RL5 - host keeps load clock driven afterwards
// RL6 - data pin becomes user pin after configuration
// RL7 - complete released only after full bitstream
// RL8 - host gives two falling edges after complete
// RL9 - init pin low until initialization ends
// RL10 - complete and ready low within 600 ns
// RL11 - host holds request low at least 2 us
// RL12 - ready low 268 to 1506 us
// RL13 - ready released within 1506 us of request
// RL14 - host waits 2 us after ready rises
// RL15 - data captured on rising load clock edge
// RL16 - oscillator init: user mode 175-437 us
// RL17 - user clock enabled, then 8576 cycles
// RL18 - init clock: oscillator, user clock, load clock
// RL19 - at least 8576 init clock cycles
// RL20 - user clock used only when option loaded
// RL21 - host restarts when ready drops while loading
// RL22 - host stops load clock unless it initializes
package psl_pkg;
  localparam int CNT_W           = 18;
  typedef logic [CNT_W-1:0] psl_cnt_type;

  localparam int CLK_PERIOD_NS   = 10;
  localparam int US_NS           = 1000;
  localparam int T_CF2ST0_NS     = 600;
  localparam int T_CFG_NS        = 2000;
  localparam int T_STATUS_MIN_US = 268;
  localparam int T_STATUS_MAX_US = 1506;
  localparam int T_ST2CK_NS      = 2000;
  localparam int T_CD2UM_MIN_US  = 175;
  localparam int LCLK_FMAX_MHZ   = 125;
  localparam int CD2CU_PERIODS   = 4;
  localparam int INIT_CYCLES     = 8576;
  localparam int POST_FALLS      = 2;

  // least times round up to whole cycles
  function automatic psl_cnt_type cyc_ceil(input int t_ns);
    cyc_ceil = psl_cnt_type'((t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

  // longest times round down
  function automatic psl_cnt_type cyc_floor(input int t_ns);
    cyc_floor = psl_cnt_type'(t_ns / CLK_PERIOD_NS);
  endfunction

  localparam psl_cnt_type CF2ST0_CYC     = cyc_floor(T_CF2ST0_NS);
  localparam psl_cnt_type CFG_CYC        = cyc_ceil(T_CFG_NS);
  localparam psl_cnt_type STATUS_MIN_CYC = cyc_ceil(T_STATUS_MIN_US * US_NS);
  localparam psl_cnt_type STATUS_MAX_CYC = cyc_floor(T_STATUS_MAX_US * US_NS);
  localparam psl_cnt_type ST2CK_CYC      = cyc_ceil(T_ST2CK_NS);
  localparam psl_cnt_type CD2UM_MIN_CYC  = cyc_ceil(T_CD2UM_MIN_US * US_NS);
  localparam psl_cnt_type CD2CU_CYC      = cyc_ceil(CD2CU_PERIODS * US_NS / LCLK_FMAX_MHZ);
  localparam psl_cnt_type INIT_CYC       = psl_cnt_type'(INIT_CYCLES);

  // option word: first bits of the bitstream, lsb first
  localparam int OPT_W         = 4;
  localparam int OPT_INIT_PIN  = 0;
  localparam int OPT_SRC_LO    = 1;
  localparam int OPT_DATA_USER = 3;
  localparam logic [1:0] SRC_OSC  = 2'h0;
  localparam logic [1:0] SRC_USER = 2'h1;
  localparam logic [1:0] SRC_LCLK = 2'h2;
  localparam logic [1:0] SRC_BAD  = 2'h3;

  localparam int DEF_BITS      = 64;
  localparam int DEF_LCLK_HALF = 8;
endpackage

// ==== psl_if.sv ====
// pin-level carrier between configuration host and device
`timescale 1ns/1ps
interface psl_if;
  logic config_request_n;
  logic serial_load_clock;
  logic host_data;
  logic host_data_oe_n;
  logic host_status;
  logic host_status_oe_n;
  logic dev_data;
  logic dev_data_oe_n;
  logic dev_status;
  logic dev_status_oe_n;
  logic dev_done;
  logic dev_done_oe_n;
  logic init_complete;
  logic ready_flag_n;
  logic load_complete;
  logic serial_load_data;

  // open-drain wires with pull-ups; either party may pull ready low, only the device pulls complete low
  assign ready_flag_n  = (dev_status_oe_n | dev_status) & (host_status_oe_n | host_status);
  assign load_complete = dev_done_oe_n | dev_done;
  // shared data wire, pulled high when nobody drives
  assign serial_load_data = !host_data_oe_n ? host_data : (!dev_data_oe_n ? dev_data : 1'b1);

  modport dev (
    input  config_request_n, serial_load_clock, serial_load_data, ready_flag_n,
    output dev_data, dev_data_oe_n, dev_status, dev_status_oe_n, dev_done, dev_done_oe_n,
    output init_complete
  );
  modport host (
    output config_request_n, serial_load_clock, host_data, host_data_oe_n,
    output host_status, host_status_oe_n,
    input  ready_flag_n, load_complete, serial_load_data, init_complete
  );
endinterface

// ==== psl_sync.sv ====
// two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module psl_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         srst,
  // pins in, synchronised out
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] sync
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_q <= RST_VAL;
      sync   <= RST_VAL;
    end else begin
      meta_q <= pin;
      sync   <= meta_q;
    end
  end
endmodule

// ==== psl_dev.sv ====
// device end: passive serial configuration port with initialization
`timescale 1ns/1ps
module psl_dev
  import psl_pkg::*;
#(
  parameter int          BITS       = DEF_BITS,
  parameter psl_cnt_type STATUS_CYC = STATUS_MIN_CYC,
  parameter psl_cnt_type OSC_CYC    = CD2UM_MIN_CYC,
  parameter psl_cnt_type INIT_CNT   = INIT_CYC
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // link pins
  psl_if.dev        link,
  // user-side clock and pin
  input  wire logic user_startup_clock,
  input  wire logic user_data_out,
  input  wire logic user_data_oe,
  // user-side status
  output logic      user_data_in,
  output logic      user_mode,
  output logic      cfg_error
);
  localparam int BW = $clog2(BITS + 1);

  typedef enum logic [3:0] {
    ST_STATUS, ST_CLEAR, ST_WAIT_READY, ST_LOAD, ST_EDGES,
    ST_CU_WAIT, ST_INIT, ST_USER, ST_ERROR
  } psl_dstate_type;

  // synchronised pins: request, load clock, data, ready wire, user clock
  logic [4:0] pin_s;
  logic       req_s;
  logic       lclk_s;
  logic       data_s;
  logic       rdy_s;
  logic       uclk_s;

  psl_sync #(.W(5), .RST_VAL(5'h1F)) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .pin      ({link.config_request_n, link.serial_load_clock, link.serial_load_data,
                link.ready_flag_n, user_startup_clock}),
    .sync     (pin_s)
  );
  assign {req_s, lclk_s, data_s, rdy_s, uclk_s} = pin_s;

  psl_dstate_type       state_q, state_d;
  psl_cnt_type          cnt_q, cnt_d;
  logic [BW-1:0]        bits_q, bits_d;
  logic [OPT_W-1:0]     opt_q, opt_d;
  logic                 lclk_p_q, uclk_p_q;
  logic                 lclk_rise, lclk_fall, uclk_rise;
  logic                 tick;
  psl_cnt_type          target;
  logic [1:0]           src;

  assign lclk_rise = lclk_s & ~lclk_p_q;
  assign lclk_fall = ~lclk_s & lclk_p_q;
  assign uclk_rise = uclk_s & ~uclk_p_q;
  assign src       = opt_q[OPT_SRC_LO +: 2];

  // initialization tick and length follow the loaded clock source
  always_comb begin
    unique case (src)
      SRC_USER: begin
        tick   = uclk_rise; // RL20
        target = INIT_CNT; // RL17 RL19
      end
      SRC_LCLK: begin
        tick   = lclk_rise; // RL18
        target = INIT_CNT; // RL19
      end
      default: begin
        tick   = 1'b1; // RL16
        target = OSC_CYC; // RL16
      end
    endcase
  end

  // sequencer: next state, counters and loaded options
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    bits_d  = bits_q;
    opt_d   = opt_q;
    if (!req_s) begin
      state_d = ST_CLEAR; // RL2
      if (state_q != ST_CLEAR) begin
        cnt_d = '0;
      end else if (cnt_q != '1) begin
        cnt_d = cnt_q + 1'b1;
      end
    end else begin
      unique case (state_q)
        ST_CLEAR: begin
          state_d = ST_STATUS;
          cnt_d   = (cnt_q == '1) ? cnt_q : cnt_q + 1'b1;
        end
        ST_STATUS: begin
          // low time counts from the request edge, so a long request does not stretch it
          if (cnt_q >= STATUS_CYC - 1'b1) begin
            state_d = ST_WAIT_READY; // RL3 RL12 RL13
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
        ST_WAIT_READY: begin
          // host may keep the wire low to delay loading
          if (rdy_s) begin
            state_d = ST_LOAD;
            bits_d  = '0;
            opt_d   = '0;
          end
        end
        ST_LOAD: begin
          if (lclk_rise) begin
            if (bits_q < BW'(OPT_W)) begin
              opt_d[bits_q[$clog2(OPT_W)-1:0]] = data_s; // RL15
            end
            bits_d = bits_q + 1'b1;
            if (bits_q == BW'(BITS - 1)) begin
              // an illegal clock source counts as a failed load
              if (opt_d[OPT_SRC_LO +: 2] == SRC_BAD) begin
                state_d = ST_ERROR;
              end else begin
                state_d = ST_EDGES; // RL7
                cnt_d   = '0;
              end
            end
          end
        end
        ST_EDGES: begin
          if (lclk_fall) begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == psl_cnt_type'(POST_FALLS - 1)) begin
              state_d = ST_CU_WAIT;
              cnt_d   = '0;
            end
          end
        end
        ST_CU_WAIT: begin
          // user clock is ignored until four worst-case load clock periods pass
          if (src != SRC_USER || cnt_q >= CD2CU_CYC - 1'b1) begin
            state_d = ST_INIT; // RL17
            cnt_d   = '0;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
        ST_INIT: begin
          if (tick) begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q >= target - 1'b1) begin
              state_d = ST_USER; // RL19
            end
          end
        end
        ST_USER: begin
          state_d = ST_USER;
        end
        ST_ERROR: begin
          state_d = ST_ERROR;
        end
        default: begin
          state_d = ST_ERROR;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q  <= ST_STATUS;
      cnt_q    <= '0;
      bits_q   <= '0;
      opt_q    <= '0;
      lclk_p_q <= 1'b1; // matches the sync reset level, so no false rise
      uclk_p_q <= 1'b1;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      bits_q   <= bits_d;
      opt_q    <= opt_d;
      lclk_p_q <= lclk_s;
      uclk_p_q <= uclk_s;
    end
  end

  // pin drivers, all registered; enables and flags decoded from the next state
  logic status_oe_n_d, done_oe_n_d, init_d, data_oe_n_d, data_d;
  logic status_oe_n_q, done_oe_n_q, init_q, data_oe_n_q, data_q;
  logic user_in_d, user_mode_d, err_d;
  logic user_in_q, user_mode_q, err_q;

  always_comb begin
    // ready held low during power-up, request, status window and error
    status_oe_n_d = !(state_d inside {ST_STATUS, ST_CLEAR, ST_ERROR}); // RL3 RL10 RL1
    done_oe_n_d   = state_d inside {ST_EDGES, ST_CU_WAIT, ST_INIT, ST_USER}; // RL4 RL7 RL10
    init_d        = !(opt_d[OPT_INIT_PIN] && state_d inside {ST_EDGES, ST_CU_WAIT, ST_INIT}); // RL9
    user_mode_d   = state_d == ST_USER; // RL1
    data_oe_n_d   = !(user_mode_d && opt_d[OPT_DATA_USER] && user_data_oe); // RL6
    data_d        = user_data_out;
    user_in_d     = user_mode_d ? data_s : 1'b0; // RL6
    err_d         = state_d == ST_ERROR;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      status_oe_n_q <= 1'b0;
      done_oe_n_q   <= 1'b0;
      init_q        <= 1'b1;
      data_oe_n_q   <= 1'b1;
      data_q        <= 1'b0;
      user_in_q     <= 1'b0;
      user_mode_q   <= 1'b0;
      err_q         <= 1'b0;
    end else begin
      status_oe_n_q <= status_oe_n_d;
      done_oe_n_q   <= done_oe_n_d;
      init_q        <= init_d;
      data_oe_n_q   <= data_oe_n_d;
      data_q        <= data_d;
      user_in_q     <= user_in_d;
      user_mode_q   <= user_mode_d;
      err_q         <= err_d;
    end
  end

  // open-drain pins only ever pull low
  assign link.dev_status      = 1'b0;
  assign link.dev_status_oe_n = status_oe_n_q;
  assign link.dev_done        = 1'b0;
  assign link.dev_done_oe_n   = done_oe_n_q;
  assign link.init_complete   = init_q;
  assign link.dev_data        = data_q;
  assign link.dev_data_oe_n   = data_oe_n_q;
  assign user_data_in         = user_in_q;
  assign user_mode            = user_mode_q;
  assign cfg_error            = err_q;
endmodule

// ==== psl_host.sv ====
// host end: drives request, load clock and serial bitstream
`timescale 1ns/1ps
module psl_host
  import psl_pkg::*;
#(
  parameter int          BITS      = DEF_BITS,
  parameter int          LCLK_HALF = DEF_LCLK_HALF,
  parameter psl_cnt_type READY_MAX = STATUS_MAX_CYC
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // link pins
  psl_if.host       link,
  // user-side control
  input  wire logic cfg_start,
  input  wire logic keep_clock,
  input  wire logic bit_in,
  // user-side status
  output logic      bit_take,
  output logic      busy,
  output logic      cfg_done,
  output logic      cfg_error
);
  localparam int BW = $clog2(BITS + 1);
  localparam int DW = $clog2(LCLK_HALF + 1);

  typedef enum logic [2:0] {
    H_IDLE, H_PULSE, H_WAIT_READY, H_SETTLE, H_SHIFT, H_CHECK, H_EDGES, H_DONE
  } psl_hstate_type;

  logic rdy_s, done_s;

  psl_sync #(.W(2), .RST_VAL(2'h0)) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .pin      ({link.ready_flag_n, link.load_complete}),
    .sync     ({rdy_s, done_s})
  );

  psl_hstate_type state_q, state_d;
  psl_cnt_type    cnt_q, cnt_d;
  logic [BW-1:0]  bits_q, bits_d;
  logic [DW-1:0]  div_q, div_d;
  logic           tick;
  logic           lclk_q, lclk_d, data_q, data_d, take_q, take_d, err_q, err_d;

  // load clock divider: one enable pulse per half period
  assign tick  = div_q == '0;
  assign div_d = tick ? DW'(LCLK_HALF - 1) : div_q - 1'b1;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + 1'b1;
    bits_d  = bits_q;
    lclk_d  = lclk_q;
    data_d  = data_q;
    take_d  = 1'b0;
    err_d   = err_q;
    unique case (state_q)
      H_IDLE, H_DONE: begin
        // clock parked at a driven level unless it clocks initialization
        if (state_q == H_DONE && keep_clock && tick) begin
          lclk_d = ~lclk_q; // RL22
        end else if (!keep_clock) begin
          lclk_d = 1'b0; // RL5 RL22
        end
        if (cfg_start) begin
          state_d = H_PULSE; // RL2
          cnt_d   = '0;
          err_d   = 1'b0;
          lclk_d  = 1'b0;
        end
      end
      H_PULSE: begin
        if (cnt_q >= CFG_CYC - 1'b1) begin
          state_d = H_WAIT_READY; // RL11
          cnt_d   = '0;
        end
      end
      H_WAIT_READY: begin
        if (rdy_s) begin
          state_d = H_SETTLE; // RL14
          cnt_d   = '0;
        end else if (cnt_q >= READY_MAX) begin
          state_d = H_IDLE;
          err_d   = 1'b1;
        end
      end
      H_SETTLE: begin
        if (cnt_q >= ST2CK_CYC - 1'b1) begin
          state_d = H_SHIFT; // RL14
          bits_d  = '0;
          data_d  = bit_in; // RL15
          take_d  = 1'b1;
        end
      end
      H_SHIFT: begin
        if (!rdy_s) begin
          state_d = H_PULSE; // RL21
          cnt_d   = '0;
          lclk_d  = 1'b0;
        end else if (tick) begin
          lclk_d = ~lclk_q;
          if (lclk_q) begin
            bits_d = bits_q + 1'b1;
            if (bits_q == BW'(BITS - 1)) begin
              state_d = H_CHECK;
            end else begin
              data_d = bit_in; // RL15
              take_d = 1'b1;
            end
          end
        end
      end
      H_CHECK: begin
        // one half period lets the completion flag cross both domains
        if (tick) begin
          if (done_s) begin
            state_d = H_EDGES;
            bits_d  = '0;
          end else begin
            state_d = H_IDLE;
            err_d   = 1'b1;
          end
        end
      end
      H_EDGES: begin
        if (tick) begin
          lclk_d = ~lclk_q;
          if (lclk_q) begin
            bits_d = bits_q + 1'b1;
            if (bits_q == BW'(POST_FALLS - 1)) begin
              state_d = H_DONE; // RL8
            end
          end
        end
      end
    endcase
    if (cnt_q == '1) begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= H_IDLE;
      cnt_q   <= '0;
      bits_q  <= '0;
      div_q   <= '0;
      lclk_q  <= 1'b0;
      data_q  <= 1'b0;
      take_q  <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      bits_q  <= bits_d;
      div_q   <= div_d;
      lclk_q  <= lclk_d;
      data_q  <= data_d;
      take_q  <= take_d;
      err_q   <= err_d;
    end
  end

  // data driven only while loading; afterwards the pin belongs to the device
  logic req_n_q, oe_n_q, busy_q, done_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      req_n_q <= 1'b1;
      oe_n_q  <= 1'b1;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      req_n_q <= state_d != H_PULSE; // RL2 RL11
      oe_n_q  <= !(state_d inside {H_SETTLE, H_SHIFT, H_CHECK, H_EDGES});
      busy_q  <= !(state_d inside {H_IDLE, H_DONE});
      done_q  <= state_d == H_DONE;
    end
  end

  assign link.config_request_n  = req_n_q;
  assign link.serial_load_clock = lclk_q;
  assign link.host_data         = data_q;
  assign link.host_data_oe_n    = oe_n_q;
  assign link.host_status       = 1'b0;
  assign link.host_status_oe_n  = 1'b1;
  assign bit_take               = take_q;
  assign busy                   = busy_q;
  assign cfg_done               = done_q;
  assign cfg_error              = err_q;
endmodule

// ==== psl_monitor.sv ====
// concurrent checks on the configuration link between host and device
`timescale 1ns/1ps
module psl_monitor #(
  parameter int BITS       = 16,
  parameter int STATUS_CYC = 50
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // link wires
  input wire logic config_request_n,
  input wire logic serial_load_clock,
  input wire logic serial_load_data,
  input wire logic host_data_oe_n,
  input wire logic dev_data_oe_n,
  input wire logic ready_flag_n,
  input wire logic load_complete,
  input wire logic init_complete
);
  localparam int CF2ST0 = 60;
  localparam int CFG    = 200;
  localparam int ST2CK  = 200;
  localparam int ST_MAX = 1000;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  logic [15:0] since_req_q, since_req_d, low_q, low_d, rdy_q, rdy_d, rises_q, rises_d;
  logic        req_q, clk_q;

  // since_req_q and rdy_q saturate so a long idle spell cannot wrap them back under a bound
  always_comb begin
    since_req_d = (req_q && !config_request_n) ? 16'h0000 : since_req_q + 16'(!(&since_req_q));
    low_d       = config_request_n ? 16'h0000 : low_q + 16'h0001;
    rdy_d       = !ready_flag_n ? 16'h0000 : rdy_q + 16'(!(&rdy_q));
    rises_d     = !config_request_n ? 16'h0000 : rises_q + 16'(serial_load_clock && !clk_q);
  end

  // registers only
  always_ff @(posedge core_clk) begin
    if (srst) begin
      since_req_q <= 16'h0000;
      low_q       <= 16'h0000;
      rdy_q       <= 16'h0000;
      rises_q     <= 16'h0000;
      req_q       <= 1'b1;
      clk_q       <= 1'b0;
    end else begin
      since_req_q <= since_req_d;
      low_q       <= low_d;
      rdy_q       <= rdy_d;
      rises_q     <= rises_d;
      req_q       <= config_request_n;
      clk_q       <= serial_load_clock;
    end
  end

  property p_req_to_low;
    $fell(config_request_n) |-> ##[1:CF2ST0] (!ready_flag_n && !load_complete);
  endproperty
  a_req_to_low: assert property (p_req_to_low) else $error("status or done not low after request");

  property p_done_rise;
    $rose(load_complete) |-> ready_flag_n && config_request_n;
  endproperty
  a_done_rise: assert property (p_done_rise) else $error("done rose outside loading");

  property p_bits;
    $rose(load_complete) |-> rises_q == BITS;
  endproperty
  a_bits: assert property (p_bits) else $error("done rose before the whole bitstream");

  // two sync stages give the device a little slack after power-up
  property p_ready_min;
    $rose(ready_flag_n) |-> since_req_q >= STATUS_CYC - 2;
  endproperty
  a_ready_min: assert property (p_ready_min) else $error("status low pulse too short");

  property p_ready_rel;
    $rose(config_request_n) |-> ##[1:ST_MAX] ready_flag_n;
  endproperty
  a_ready_rel: assert property (p_ready_rel) else $error("status not released after request");

  property p_dev_data;
    !dev_data_oe_n |-> load_complete && host_data_oe_n;
  endproperty
  a_dev_data: assert property (p_dev_data) else $error("device drives data pin while loading");

  property p_init_end;
    $rose(init_complete) |-> load_complete;
  endproperty
  a_init_end: assert property (p_init_end) else $error("init ended before done");

  property p_first_clk;
    $rose(serial_load_clock) |-> rdy_q >= ST2CK;
  endproperty
  a_first_clk: assert property (p_first_clk) else $error("load clock rose too soon after status");

  property p_req_width;
    $rose(config_request_n) |-> low_q >= CFG;
  endproperty
  a_req_width: assert property (p_req_width) else $error("request pulse too short");

  property p_capture;
    $rose(serial_load_clock) && !host_data_oe_n |-> $stable(serial_load_data);
  endproperty
  a_capture: assert property (p_capture) else $error("data moved at rising load clock");
endmodule

// ==== psl_tb_top.sv ====
// self-checking bench: host and device joined, plus a device driven by hand
`timescale 1ns/1ps
module psl_tb_top import psl_pkg::*;;
  localparam int NB  = 16;
  localparam int ST  = 50;
  localparam int OSC = 40;
  localparam int INI = 8;

  logic        core_clk, srst, uclk, cfg_start, keep_clock, bit_in, user_data_out, user_data_oe;
  logic        bit_take, busy, cfg_done, h_err, user_data_in, user_mode, d_err, f_udi, f_um, f_err;
  logic [15:0] stream;
  int          idx, err_count, comparisons;

  psl_if pi ();
  psl_if fi ();

  psl_host #(.BITS(NB)) psl_host_inst (.core_clk(core_clk), .srst(srst), .link(pi), .cfg_start(cfg_start),
    .keep_clock(keep_clock), .bit_in(bit_in), .bit_take(bit_take), .busy(busy), .cfg_done(cfg_done),
    .cfg_error(h_err));
  psl_dev #(.BITS(NB), .STATUS_CYC(psl_cnt_type'(ST)), .OSC_CYC(psl_cnt_type'(OSC)),
    .INIT_CNT(psl_cnt_type'(INI))) psl_dev_inst (.core_clk(core_clk), .srst(srst), .link(pi),
    .user_startup_clock(uclk), .user_data_out(user_data_out), .user_data_oe(user_data_oe),
    .user_data_in(user_data_in), .user_mode(user_mode), .cfg_error(d_err));
  // second device faces the bench, which breaks the host's side on purpose
  psl_dev #(.BITS(NB), .STATUS_CYC(psl_cnt_type'(ST)), .OSC_CYC(psl_cnt_type'(OSC)),
    .INIT_CNT(psl_cnt_type'(INI))) psl_dev_inst2 (.core_clk(core_clk), .srst(srst), .link(fi),
    .user_startup_clock(uclk), .user_data_out(1'b0), .user_data_oe(1'b0),
    .user_data_in(f_udi), .user_mode(f_um), .cfg_error(f_err));
  psl_monitor #(.BITS(NB), .STATUS_CYC(ST)) psl_monitor_inst (.core_clk(core_clk), .srst(srst),
    .config_request_n(pi.config_request_n), .serial_load_clock(pi.serial_load_clock),
    .serial_load_data(pi.serial_load_data), .host_data_oe_n(pi.host_data_oe_n),
    .dev_data_oe_n(pi.dev_data_oe_n), .ready_flag_n(pi.ready_flag_n),
    .load_complete(pi.load_complete), .init_complete(pi.init_complete));

  // clocks; the start-up clock runs at a slightly odd rate so it drifts against core_clk
  always #5 core_clk = ~core_clk;
  always #9.7 uclk = ~uclk;

  // host asks for the next bit with bit_take; it is held a full load clock period
  always @(negedge core_clk) begin
    if (bit_take === 1'b1) idx <= idx + 1;
    bit_in <= stream[idx[3:0]];
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic summarize();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // hand-driven host: one bit per load clock period, data set while the clock is low
  task automatic f_bit(input logic b);
    fi.host_data = b;
    fi.host_data_oe_n = 1'b0;
    cyc(8);
    fi.serial_load_clock = 1'b1;
    cyc(8);
    fi.serial_load_clock = 1'b0;
  endtask

  task automatic f_req(input int hold);
    int n;
    fi.config_request_n = 1'b0;
    cyc(hold);
    fi.config_request_n = 1'b1;
    for (n = 0; n < 1000 && fi.ready_flag_n !== 1'b1; n++) cyc(1);
    cyc(200);
  endtask

  task automatic t_powerup();
    check({pi.ready_flag_n, pi.load_complete, user_mode}, 3'h0);
    cyc(ST - 15);
    check(pi.ready_flag_n, 1'b0);
    cyc(30);
    check({pi.ready_flag_n, pi.config_request_n}, 2'h3);
    $display("powerup test done");
  endtask

  task automatic t_config(input logic [3:0] opt, input logic keep);
    int n, lim;
    lim = (opt[2:1] == SRC_OSC) ? OSC : (opt[2:1] == SRC_USER) ? 15 : 16 * INI;
    keep_clock = keep;
    stream = {12'ha5c, opt};
    idx = 0;
    cfg_start = 1'b1;
    cyc(1);
    cfg_start = 1'b0;
    cyc(12);
    check({user_mode, busy}, 2'h1);
    check({pi.ready_flag_n, pi.load_complete}, 2'h0);
    for (n = 0; n < 3000 && pi.load_complete !== 1'b1; n++) cyc(1);
    check(pi.init_complete, !opt[0]);
    for (n = 0; n < 3000 && user_mode !== 1'b1; n++) cyc(1);
    check(n >= lim, 1'b1);
    check({user_mode, cfg_done, busy, h_err, d_err}, 5'h18);
    check({pi.config_request_n, pi.ready_flag_n, pi.load_complete, pi.init_complete}, 4'hf);
    user_data_oe = 1'b1;
    for (int v = 0; v < 2; v++) begin
      user_data_out = v[0];
      cyc(4);
      check({pi.serial_load_data, user_data_in}, opt[3] ? {2{v[0]}} : 2'h3);
    end
    user_data_oe = 1'b0;
    $display("config test %h done", opt);
  endtask

  task automatic t_partial();
    int n;
    f_req(200);
    for (n = 0; n < NB - 1; n++) f_bit(n[0] & n[2]);
    cyc(20);
    check(fi.load_complete, 1'b0);
    f_bit(1'b1);
    cyc(20);
    check(fi.load_complete, 1'b1);
    // the last bit's own fall came after completion, so one more fall makes two
    f_bit(1'b0);
    fi.host_data_oe_n = 1'b1;
    for (n = 0; n < 300 && f_um !== 1'b1; n++) cyc(1);
    check({f_um, n >= OSC - 4, f_udi}, 3'h7);
    $display("partial load test done");
  endtask

  // host side holds the status wire low to delay configuration
  task automatic t_hold();
    fi.host_status_oe_n = 1'b0;
    fi.config_request_n = 1'b0;
    cyc(10);
    check({f_um, fi.load_complete}, 2'h0);
    cyc(190);
    fi.config_request_n = 1'b1;
    cyc(150);
    fi.host_status_oe_n = 1'b1;
    cyc(10);
    check({fi.ready_flag_n, fi.load_complete}, 2'h2);
    cyc(200);
    $display("held status test done");
  endtask

  task automatic t_illegal();
    for (int n = 0; n < NB; n++) f_bit(n == 1 || n == 2);
    fi.host_data_oe_n = 1'b1;
    cyc(20);
    check({f_err, fi.ready_flag_n, fi.load_complete}, 3'h4);
    $display("illegal source test done");
  endtask

  // watchdog: the whole run needs well under this many cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    summarize();
  end

  // main sequence
  initial begin
    {core_clk, uclk, cfg_start, keep_clock, bit_in, user_data_out, user_data_oe} = 7'h00;
    {fi.config_request_n, fi.serial_load_clock, fi.host_data, fi.host_data_oe_n} = 4'h9;
    {fi.host_status, fi.host_status_oe_n} = 2'h1;
    stream = 16'h0000;
    idx = 0;
    err_count = 0;
    comparisons = 0;
    srst = 1'b1;
    cyc(5);
    srst = 1'b0;
    t_powerup();
    t_config(4'h8, 1'b0);
    t_config(4'h3, 1'b0);
    t_partial();
    t_hold();
    t_illegal();
    t_config(4'h5, 1'b1);
    summarize();
  end
endmodule
